// *** inc/erx_defines.vh ***
// Constants for the receive checksum, counters and FIFO block
`ifndef ERX_DEFINES_VH
`define ERX_DEFINES_VH
`define ERX_A_OPMODE 8'h00
`define ERX_A_MISSED 8'h04
`define ERX_A_LEVEL 8'h08
`define ERX_OP_SAF 25
`define ERX_OP_DROPDIS 26
`define ERX_ND_MAX 16'hffff
`define ERX_OF_MAX 11'h7ff
`define ERX_ST_CSUM 0
`define ERX_ST_OVF 1
`define ERX_FREE_OVF 5'h02
`define ERX_DEPTH 16
`define ERX_AW 4
`define ERX_FW 38
`define ERX_TAG_TS 4'h0
`define ERX_TAG_ST 4'hf
`define ERX_K_DATA 2'h0
`define ERX_K_TS 2'h1
`define ERX_K_ST 2'h2
`define ERX_P_ETH_HI 16'h000c
`define ERX_P_ETH_LO 16'h000d
`define ERX_P_IP 16'h000e
`define ERX_P_V4LEN_HI 16'h0010
`define ERX_P_V4LEN_LO 16'h0011
`define ERX_P_V4PROTO 16'h0017
`define ERX_P_V4SRC 16'h001a
`define ERX_P_V4DST_END 16'h0021
`define ERX_P_V6LEN_HI 16'h0012
`define ERX_P_V6LEN_LO 16'h0013
`define ERX_P_V6NH 16'h0014
`define ERX_P_V6SRC 16'h0016
`define ERX_P_V6DST_END 16'h0035
`define ERX_P_V6PAY 16'h0036
`define ERX_MIN_FRAME 16'h003c
`define ERX_ET_V4 16'h0800
`define ERX_ET_V6 16'h86dd
`define ERX_PR_ICMP 8'h01
`define ERX_PR_TCP 8'h06
`define ERX_PR_UDP 8'h11
`define ERX_PR_ICMP6 8'h3a
`define ERX_EH_HOP 8'h00
`define ERX_EH_RT 8'h2b
`define ERX_EH_FRAG 8'h2c
`define ERX_EH_DST 8'h3c
`define ERX_EH_AUTH 8'h33
`define ERX_EH_BASE 16'h0008
`define ERX_CSUM_OK 16'hffff
`endif

// *** verilog/erx_top.v ***
// Receive checksum check, loss counters and receive FIFO controllers
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "erx_defines.vh"
// Contract
// - Verify TCP/UDP/ICMP checksum, flag mismatch in status
// - Flag payload length differing from IP header
// - Walk IPv6 extension headers to find payload
// - Extension header size is length*8 plus 8
// - Authentication header size is length*4 plus 8
// - Drop-disable bit forwards frames with checksum errors
// - Count no-descriptor losses and FIFO overflow losses
// - One register, rollover flags at 16 and 28
// - Rollover flags stay set until register read
// - Overflow when non-EOF word meets two free
// - On overflow write dummy EOF, then overflow status
// - After overflow discard rest, timestamp and status
// - Timestamp follows EOF, tagged all-zero byte enables
// - Status word last, tagged all-one byte enables
// - Reader decodes tags as timestamp or status
// - All-zero byte enables on EOF mean one byte
// - Store-and-forward mode is supported

module erx_fifo #(
   parameter W = 38,
   parameter D = 16,
   parameter AW = 4
) (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Fill side
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   // Drain side
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data,
   output wire [AW:0] level
);
   localparam [AW:0] DL = D;
   reg [W-1:0] mem_r [0:D-1];
   reg [AW:0] wp_r;
   reg [AW:0] rp_r;
   wire push;
   wire pop;
   assign level = wp_r - rp_r;
   assign in_ready = (level != DL);
   assign out_valid = (level != {(AW+1){1'b0}});
   assign out_data = mem_r[rp_r[AW-1:0]];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   always @(posedge clk) begin
      if (push) begin
         mem_r[wp_r[AW-1:0]] <= in_data;
      end
   end
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r <= {(AW+1){1'b0}};
         rp_r <= {(AW+1){1'b0}};
      end else begin
         if (push) wp_r <= wp_r + 1'b1;
         if (pop) rp_r <= rp_r + 1'b1;
      end
   end
endmodule // erx_fifo

module erx_top (
   // APB
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // MAC receiver side port
   input wire mrx_valid,
   input wire [31:0] mrx_data,
   input wire [3:0] mrx_be,
   input wire mrx_eof,
   input wire mrx_ts_valid,
   input wire [31:0] mrx_ts,
   input wire mrx_stat_valid,
   input wire [31:0] mrx_stat,
   // DMA
   input wire dma_no_desc,
   // Host read port
   input wire host_ready,
   output reg host_valid,
   output reg [1:0] host_kind,
   output reg [31:0] host_data,
   output reg [3:0] host_be,
   output reg host_eof
);
   localparam [1:0] W_DATA = 2'h0;
   localparam [1:0] W_OVS = 2'h1;
   localparam [1:0] W_DROP = 2'h2;
   localparam [1:0] W_CTL = 2'h3;
   localparam [1:0] R_IDLE = 2'h0;
   localparam [1:0] R_PASS = 2'h1;
   localparam [1:0] R_FLUSH = 2'h2;
   localparam [4:0] DEPTH_L = `ERX_DEPTH;

   integer i;
   // Registers
   reg saf_r, drop_csum_err_disable_r;
   reg [15:0] nd_cnt_r;
   reg [10:0] of_cnt_r;
   reg nd_flag_r, of_flag_r;
   reg [1:0] wst_r, wst_nxt, rst_r, rst_nxt;
   reg pts_v_r, pts_v_nxt, pstat_v_r, pstat_v_nxt, skip_r, skip_nxt;
   reg [31:0] pts_r, pts_nxt, pstat_r, pstat_nxt;
   reg [15:0] pos_r, pos_nxt, len_r, len_nxt, hs_r, hs_nxt, pay_r, pay_nxt;
   reg [15:0] cnt_r, cnt_nxt, plen;
   reg [7:0] ehi_r, ehi_nxt, pro_r, pro_nxt, nh_r, nh_nxt, nnh_r, nnh_nxt, b;
   reg [3:0] ihl_r, ihl_nxt, bev;
   reg ip4_r, ip4_nxt, ip6_r, ip6_nxt, fnd_r, fnd_nxt, cerr_r, cerr_nxt;
   reg [31:0] sum_r, sum_nxt, psum_r, psum_nxt, tot, f1;
   reg [15:0] f2;
   reg mism;
   // FIFO hookup
   reg w_valid, v_push, ovf_ev, f_ready, v_ready, load;
   reg [`ERX_FW-1:0] w_data;
   wire w_ready, f_valid, v_valid, v_ready_unused;
   wire [`ERX_FW-1:0] f_data;
   wire [0:0] v_data;
   wire [4:0] level;
   wire [4:0] vlevel;
   wire [4:0] free;
   wire is_ctl, is_st, slot_free, apb_done, rd_clr;
   wire [1:0] kind;

   function [31:0] wt;
      input [7:0] bb;
      input odd;
      begin
         wt = odd ? {24'h0, bb} : {16'h0, bb, 8'h0};
      end
   endfunction

   function is_ext;
      input [7:0] n;
      begin
         is_ext = (n == `ERX_EH_HOP) | (n == `ERX_EH_RT) | (n == `ERX_EH_FRAG) |
            (n == `ERX_EH_DST) | (n == `ERX_EH_AUTH);
      end
   endfunction

   // Header parser and checksum, byte by byte
   always @* begin
      pos_nxt = pos_r; ehi_nxt = ehi_r; ip4_nxt = ip4_r; ip6_nxt = ip6_r;
      ihl_nxt = ihl_r; len_nxt = len_r; pro_nxt = pro_r; nh_nxt = nh_r;
      nnh_nxt = nnh_r; hs_nxt = hs_r; fnd_nxt = fnd_r; pay_nxt = pay_r;
      sum_nxt = sum_r; psum_nxt = psum_r; cnt_nxt = cnt_r; cerr_nxt = cerr_r;
      b = 8'h0; plen = 16'h0; tot = 32'h0; f1 = 32'h0; f2 = 16'h0; mism = 1'b0;
      bev = (mrx_be == 4'h0) ? 4'h1 : mrx_be;
      if (mrx_valid) begin
         for (i = 0; i < 4; i = i + 1) begin
            if (bev[i]) begin
               b = mrx_data[8*i +: 8];
               if (pos_nxt == `ERX_P_ETH_HI) ehi_nxt = b;
               if (pos_nxt == `ERX_P_ETH_LO) begin
                  ip4_nxt = ({ehi_nxt, b} == `ERX_ET_V4);
                  ip6_nxt = ({ehi_nxt, b} == `ERX_ET_V6);
                  hs_nxt = `ERX_P_V6PAY;
               end
               if (ip4_nxt) begin
                  if (pos_nxt == `ERX_P_IP) ihl_nxt = b[3:0];
                  if (pos_nxt == `ERX_P_V4LEN_HI) len_nxt[15:8] = b;
                  if (pos_nxt == `ERX_P_V4LEN_LO) len_nxt[7:0] = b;
                  if (pos_nxt == `ERX_P_V4PROTO) begin
                     pro_nxt = b;
                     fnd_nxt = (b == `ERX_PR_TCP) | (b == `ERX_PR_UDP) | (b == `ERX_PR_ICMP);
                     pay_nxt = `ERX_P_IP + {10'h0, ihl_nxt, 2'h0};
                  end
                  if (pos_nxt >= `ERX_P_V4SRC && pos_nxt <= `ERX_P_V4DST_END)
                     psum_nxt = psum_nxt + wt(b, pos_nxt[0]);
               end
               if (ip6_nxt) begin
                  if (pos_nxt == `ERX_P_V6LEN_HI) len_nxt[15:8] = b;
                  if (pos_nxt == `ERX_P_V6LEN_LO) len_nxt[7:0] = b;
                  if (pos_nxt == `ERX_P_V6NH) nh_nxt = b;
                  if (pos_nxt >= `ERX_P_V6SRC && pos_nxt <= `ERX_P_V6DST_END)
                     psum_nxt = psum_nxt + wt(b, pos_nxt[0]);
                  // Size is the second byte
                  if (!fnd_nxt && is_ext(nh_nxt) && pos_nxt == hs_nxt + 16'h1) begin
                     if (nh_nxt == `ERX_EH_AUTH)
                        hs_nxt = hs_nxt + {6'h0, b, 2'h0} + `ERX_EH_BASE;
                     else
                        hs_nxt = hs_nxt + {5'h0, b, 3'h0} + `ERX_EH_BASE;
                     nh_nxt = nnh_nxt;
                  end
                  if (!fnd_nxt && pos_nxt == hs_nxt) begin
                     if (is_ext(nh_nxt)) begin
                        nnh_nxt = b;
                     end else if ((nh_nxt == `ERX_PR_TCP) | (nh_nxt == `ERX_PR_UDP) |
                        (nh_nxt == `ERX_PR_ICMP6)) begin
                        fnd_nxt = 1'b1;
                        pro_nxt = nh_nxt;
                        pay_nxt = hs_nxt;
                     end
                  end
               end
               plen = ip4_nxt ? len_nxt - {10'h0, ihl_nxt, 2'h0} :
                  len_nxt - (pay_nxt - `ERX_P_V6PAY);
               if (fnd_nxt && pos_nxt >= pay_nxt) begin
                  // Padding stays out of the sum
                  if (cnt_nxt < plen) sum_nxt = sum_nxt + wt(b, pos_nxt[0]);
                  cnt_nxt = cnt_nxt + 16'h1;
               end
               pos_nxt = pos_nxt + 16'h1;
            end
         end
         if (mrx_eof) begin
            plen = ip4_nxt ? len_nxt - {10'h0, ihl_nxt, 2'h0} :
               len_nxt - (pay_nxt - `ERX_P_V6PAY);
            tot = sum_nxt;
            if (ip6_nxt || pro_nxt != `ERX_PR_ICMP)
               tot = tot + psum_nxt + {16'h0, plen} + {24'h0, pro_nxt};
            f1 = {16'h0, tot[31:16]} + {16'h0, tot[15:0]};
            f2 = f1[15:0] + f1[31:16];
            mism = (cnt_nxt != plen) && !(cnt_nxt > plen && pos_nxt <= `ERX_MIN_FRAME);
            if (wst_r == W_DATA) cerr_nxt = fnd_nxt & ((f2 != `ERX_CSUM_OK) | mism);
            pos_nxt = 16'h0; ip4_nxt = 1'b0; ip6_nxt = 1'b0; fnd_nxt = 1'b0;
            sum_nxt = 32'h0; psum_nxt = 32'h0; cnt_nxt = 16'h0; len_nxt = 16'h0;
         end
      end
   end

   assign free = DEPTH_L - level;

   // Receive FIFO write controller
   always @* begin
      wst_nxt = wst_r; w_valid = 1'b0; w_data = {`ERX_FW{1'b0}}; v_push = 1'b0;
      ovf_ev = 1'b0; pts_v_nxt = pts_v_r; pts_nxt = pts_r; pstat_v_nxt = pstat_v_r;
      pstat_nxt = pstat_r; skip_nxt = skip_r;
      case (wst_r)
         W_DATA: begin
            if (mrx_ts_valid) begin
               pts_v_nxt = 1'b1;
               pts_nxt = mrx_ts;
            end
            if (mrx_stat_valid) begin
               pstat_v_nxt = 1'b1;
               pstat_nxt = mrx_stat;
            end
            if (mrx_valid) begin
               if (!mrx_eof && free <= `ERX_FREE_OVF) begin
                  w_valid = 1'b1;
                  w_data = {1'b0, 1'b1, `ERX_TAG_ST, 32'h0};
                  ovf_ev = 1'b1;
                  pts_v_nxt = 1'b0;
                  pstat_v_nxt = 1'b0;
                  wst_nxt = W_OVS;
               end else begin
                  w_valid = 1'b1;
                  w_data = {1'b0, mrx_eof, mrx_be, mrx_data};
                  if (mrx_eof) wst_nxt = W_CTL;
               end
            end
         end
         W_OVS: begin
            w_valid = 1'b1;
            w_data = {1'b1, 1'b0, `ERX_TAG_ST, 32'h1 << `ERX_ST_OVF};
            v_push = 1'b1;
            wst_nxt = mrx_stat_valid ? W_DATA : W_DROP;
         end
         W_DROP: begin
            if (mrx_stat_valid) begin
               wst_nxt = W_DATA;
               skip_nxt = 1'b0;
            end
         end
         default: begin
            // A frame starting early is lost whole
            if (mrx_valid && !skip_r) begin
               skip_nxt = 1'b1;
               ovf_ev = 1'b1;
            end
            if (mrx_ts_valid && !pstat_v_r) begin
               pts_v_nxt = 1'b1;
               pts_nxt = mrx_ts;
            end
            if (mrx_stat_valid) begin
               if (!pstat_v_r) begin
                  pstat_v_nxt = 1'b1;
                  pstat_nxt = mrx_stat;
               end else begin
                  skip_nxt = 1'b0;
               end
            end
            if (w_ready) begin
               if (pts_v_r) begin
                  w_valid = 1'b1;
                  w_data = {1'b1, 1'b0, `ERX_TAG_TS, pts_r};
                  pts_v_nxt = 1'b0;
               end else if (pstat_v_r) begin
                  w_valid = 1'b1;
                  w_data = {1'b1, 1'b0, `ERX_TAG_ST,
                     pstat_r | ({31'h0, cerr_r} << `ERX_ST_CSUM)};
                  pstat_v_nxt = 1'b0;
                  v_push = 1'b1;
                  wst_nxt = skip_nxt ? W_DROP : W_DATA;
               end
            end
         end
      endcase
   end

   erx_fifo #(.W(`ERX_FW), .D(`ERX_DEPTH), .AW(`ERX_AW)) u_data_fifo (
      .clk(pclk), .rst_n(presetn),
      .in_valid(w_valid), .in_ready(w_ready), .in_data(w_data),
      .out_valid(f_valid), .out_ready(f_ready), .out_data(f_data),
      .level(level)
   );

   // One verdict per stored frame: drop or forward
   erx_fifo #(.W(1), .D(`ERX_DEPTH), .AW(`ERX_AW)) u_verdict_fifo (
      .clk(pclk), .rst_n(presetn),
      .in_valid(v_push), .in_ready(v_ready_unused),
      .in_data(cerr_r & ~drop_csum_err_disable_r & (wst_r == W_CTL)),
      .out_valid(v_valid), .out_ready(v_ready), .out_data(v_data),
      .level(vlevel)
   );

   // Receive FIFO read controller
   assign is_ctl = f_data[`ERX_FW-1];
   assign is_st = is_ctl & (f_data[35:32] == `ERX_TAG_ST);
   assign kind = !is_ctl ? `ERX_K_DATA :
      (f_data[35:32] == `ERX_TAG_TS) ? `ERX_K_TS : `ERX_K_ST;
   assign slot_free = ~host_valid | host_ready;

   always @* begin
      rst_nxt = rst_r; f_ready = 1'b0; v_ready = 1'b0; load = 1'b0;
      case (rst_r)
         R_IDLE: begin
            // Store-and-forward waits for the verdict
            if (f_valid && (!saf_r || v_valid)) begin
               rst_nxt = (saf_r && v_data[0]) ? R_FLUSH : R_PASS;
            end
         end
         R_PASS: begin
            if (f_valid && slot_free) begin
               f_ready = 1'b1;
               load = 1'b1;
               if (is_st) begin
                  v_ready = v_valid;
                  rst_nxt = R_IDLE;
               end
            end
         end
         default: begin
            if (f_valid) begin
               f_ready = 1'b1;
               if (is_st) begin
                  v_ready = v_valid;
                  rst_nxt = R_IDLE;
               end
            end
         end
      endcase
   end

   // APB slave, one wait state
   assign apb_done = psel & penable & pready;
   assign rd_clr = apb_done & ~pwrite & (paddr == `ERX_A_MISSED);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0; pready <= 1'b0; pslverr <= 1'b0;
         saf_r <= 1'b0; drop_csum_err_disable_r <= 1'b0;
         nd_cnt_r <= 16'h0; of_cnt_r <= 11'h0; nd_flag_r <= 1'b0; of_flag_r <= 1'b0;
         wst_r <= W_DATA; rst_r <= R_IDLE; skip_r <= 1'b0;
         pts_v_r <= 1'b0; pts_r <= 32'h0; pstat_v_r <= 1'b0; pstat_r <= 32'h0;
         pos_r <= 16'h0; len_r <= 16'h0; hs_r <= 16'h0; pay_r <= 16'h0; cnt_r <= 16'h0;
         ehi_r <= 8'h0; pro_r <= 8'h0; nh_r <= 8'h0; nnh_r <= 8'h0; ihl_r <= 4'h0;
         ip4_r <= 1'b0; ip6_r <= 1'b0; fnd_r <= 1'b0; cerr_r <= 1'b0;
         sum_r <= 32'h0; psum_r <= 32'h0;
         host_valid <= 1'b0; host_kind <= `ERX_K_DATA; host_data <= 32'h0;
         host_be <= 4'h0; host_eof <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
         if (psel && penable && !pready) begin
            pslverr <= 1'b0;
            prdata <= 32'h0;
            if (paddr == `ERX_A_OPMODE) begin
               prdata[`ERX_OP_SAF] <= saf_r;
               prdata[`ERX_OP_DROPDIS] <= drop_csum_err_disable_r;
            end else if (paddr == `ERX_A_MISSED) begin
               prdata <= {3'h0, of_flag_r, of_cnt_r, nd_flag_r, nd_cnt_r};
            end else if (paddr == `ERX_A_LEVEL) begin
               prdata <= {27'h0, level};
            end else begin
               pslverr <= 1'b1;
            end
         end
         if (apb_done && pwrite && paddr == `ERX_A_OPMODE) begin
            saf_r <= pwdata[`ERX_OP_SAF];
            drop_csum_err_disable_r <= pwdata[`ERX_OP_DROPDIS];
         end
         if (dma_no_desc) nd_cnt_r <= nd_cnt_r + 16'h1;
         if (ovf_ev) of_cnt_r <= of_cnt_r + 11'h1;
         // Rollover beats read clear
         if (dma_no_desc && nd_cnt_r == `ERX_ND_MAX) nd_flag_r <= 1'b1;
         else if (rd_clr) nd_flag_r <= 1'b0;
         if (ovf_ev && of_cnt_r == `ERX_OF_MAX) of_flag_r <= 1'b1;
         else if (rd_clr) of_flag_r <= 1'b0;
         wst_r <= wst_nxt; rst_r <= rst_nxt; skip_r <= skip_nxt;
         pts_v_r <= pts_v_nxt; pts_r <= pts_nxt; pstat_v_r <= pstat_v_nxt; pstat_r <= pstat_nxt;
         pos_r <= pos_nxt; len_r <= len_nxt; hs_r <= hs_nxt; pay_r <= pay_nxt; cnt_r <= cnt_nxt;
         ehi_r <= ehi_nxt; pro_r <= pro_nxt; nh_r <= nh_nxt; nnh_r <= nnh_nxt; ihl_r <= ihl_nxt;
         ip4_r <= ip4_nxt; ip6_r <= ip6_nxt; fnd_r <= fnd_nxt; cerr_r <= cerr_nxt;
         sum_r <= sum_nxt; psum_r <= psum_nxt;
         if (load) begin
            host_valid <= 1'b1;
            host_kind <= kind;
            host_data <= f_data[31:0];
            host_be <= f_data[35:32];
            host_eof <= f_data[36];
         end else if (host_ready) begin
            host_valid <= 1'b0;
         end
      end
   end
endmodule // erx_top
`default_nettype wire

// *** test/erx_host_model.sv ***
// Host reader model that drains the receive FIFO port
`timescale 1ns/1ps
`default_nettype none
module erx_host_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pacing
   input wire logic stall,
   input wire logic slow,
   // Host read port
   output logic host_ready,
   input wire logic host_valid,
   input wire logic [1:0] host_kind,
   input wire logic [31:0] host_data,
   input wire logic [3:0] host_be,
   input wire logic host_eof
);
   // Accepted words
   logic [38:0] got [$];
   logic tick;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         host_ready <= 1'b0;
         tick <= 1'b0;
      end else begin
         tick <= ~tick;
         host_ready <= !stall && (!slow || tick);
         if (host_valid && host_ready)
            got.push_back({host_kind, host_eof, host_be, host_data});
      end
   end
endmodule // erx_host_model
`default_nettype wire

// *** test/erx_top_assertions.sv ***
// Port checker for the receive FIFO block
`timescale 1ns/1ps
`default_nettype none
module erx_top_checker (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Host read port
   input wire logic host_ready,
   input wire logic host_valid,
   input wire logic [1:0] host_kind,
   input wire logic [31:0] host_data,
   input wire logic [3:0] host_be,
   input wire logic host_eof
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic mapped;
   assign mapped = paddr[7:4] == 4'h0 && paddr[1:0] == 2'h0 && paddr[3:2] != 2'h3;
   sequence s_access; psel && penable && !pready; endsequence
   sequence s_answer; pready ##1 !pready; endsequence
   sequence s_eof_taken; host_valid && host_ready && host_eof; endsequence
   sequence s_stat_taken; host_valid && host_ready && host_kind == 2'h2; endsequence
   property p_wait; s_access |=> s_answer; endproperty
   a_wait: assert property (p_wait) else $error("apb answer timing");
   property p_unmapped; s_access and (!mapped && !pwrite) |=> pslverr && prdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
   property p_mapped; s_access and mapped |=> !pslverr; endproperty
   a_mapped: assert property (p_mapped) else $error("mapped refused");
   property p_level; pready && !pwrite && paddr == 8'h08 |-> prdata <= 32'h10; endproperty
   a_level: assert property (p_level) else $error("level over depth");
   property p_hold; host_valid && !host_ready |=> host_valid
      && $stable({host_kind, host_data, host_be, host_eof}); endproperty
   a_hold: assert property (p_hold) else $error("host word not held");
   property p_ts_tag; host_valid && host_kind == 2'h1 |-> host_be == 4'h0 && !host_eof; endproperty
   a_ts_tag: assert property (p_ts_tag) else $error("timestamp tag");
   property p_st_tag; host_valid && host_kind == 2'h2 |-> host_be == 4'hf && !host_eof; endproperty
   a_st_tag: assert property (p_st_tag) else $error("status tag");
   property p_after_eof; s_eof_taken |=> !host_valid || host_kind != 2'h0; endproperty
   a_after_eof: assert property (p_after_eof) else $error("data after eof");
   property p_after_st; s_stat_taken |=> !host_valid || host_kind == 2'h0; endproperty
   a_after_st: assert property (p_after_st) else $error("word after status");
   property p_kind; host_valid |-> host_kind != 2'h3 && (!host_eof || host_kind == 2'h0);
   endproperty
   a_kind: assert property (p_kind) else $error("bad kind");
endmodule // erx_top_checker
bind erx_top erx_top_checker u_chk (.*);
`default_nettype wire

// *** test/erx_top_tb.sv ***
// Bench for the receive checksum and FIFO block
`timescale 1ns/1ps
`default_nettype none
module eth_rx_checksum_fifo_status_tb_top;
   localparam logic [31:0] STAT = 32'h00000400;
   localparam logic [31:0] TS = 32'h12345678;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, mrx_data, mrx_ts, mrx_stat;
   logic [3:0] mrx_be;
   logic mrx_valid, mrx_eof, mrx_ts_valid, mrx_stat_valid, dma_no_desc, stall, slow;
   wire host_ready, host_valid, host_eof;
   wire [1:0] host_kind;
   wire [31:0] host_data;
   wire [3:0] host_be;
   int num_errors = 0;
   int tests_run = 0;
   int rdi = 0;
   logic [7:0] fr [$];
   erx_top dut (.*);
   erx_host_model m (.*);
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task automatic chk(input logic [38:0] got, input logic [38:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      if (num_errors == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Starts after an edge; one idle edge follows
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
      r = prdata;
      e = pslverr;
      chk(pready, 1'b1);
      {psel, penable} <= 2'b00;
      @(posedge pclk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic ee);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, exp);
      chk(e, ee);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   function automatic logic [31:0] w(input int i);
      w = 32'h0;
      for (int j = 0; j < 4; j++)
         if (i + j < fr.size())
            w[8 * j +: 8] = fr[i + j];
   endfunction
   function automatic logic [3:0] be_of(input int i);
      int r;
      r = fr.size() - i;
      return r >= 4 ? 4'hf : r == 1 ? 4'h0 : r == 2 ? 4'h3 : 4'h7;
   endfunction
   function automatic logic [31:0] sum16(input int a, input int b, input logic [31:0] s);
      for (int i = a; i < b; i += 2)
         s += {fr[i], (i + 1 < b) ? fr[i + 1] : 8'h00};
      return s;
   endfunction
   // UDP over IPv4, or IPv6 behind two extension headers
   task automatic build(input logic v6, input logic bad, input logic lbad, input int pay);
      logic [7:0] u;
      logic [7:0] l;
      logic [31:0] s;
      int b;
      u = 8 + pay;
      l = 20 + u + lbad;
      fr = {8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f};
      if (v6)
         fr = {fr, 8'h86, 8'hdd, 8'h60, 8'h00, 8'h00, 8'h00, 8'h00, l, 8'h00, 8'h40};
      else
         fr = {fr, 8'h08, 8'h00, 8'h45, 8'h00, 8'h00, l, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40,
            8'h11, 8'h00, 8'h00};
      for (int i = 0; i < (v6 ? 32 : 8); i++)
         fr.push_back(8'h20 + i[7:0]);
      s = sum16(v6 ? 22 : 26, fr.size(), 32'd17 + u);
      if (v6)
         fr = {fr, 8'h33, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h11, 8'h01, 8'h00,
            8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01};
      b = fr.size();
      fr = {fr, 8'h04, 8'hd2, 8'h16, 8'h2e, 8'h00, u, 8'h00, 8'h00};
      for (int i = 0; i < pay; i++)
         fr.push_back(8'ha0 + i[7:0]);
      s = sum16(b, fr.size(), s);
      s = s[15:0] + s[31:16];
      s = s[15:0] + s[31:16];
      fr[b + 6] = ~s[15:8];
      fr[b + 7] = ~s[7:0] ^ bad;
   endtask
   task automatic send(input logic ts);
      for (int i = 0; i < fr.size(); i += 4) begin
         {mrx_valid, mrx_eof, mrx_data} <= {1'b1, i + 4 >= fr.size(), w(i)};
         mrx_be <= be_of(i);
         @(posedge pclk);
      end
      {mrx_valid, mrx_eof, mrx_ts_valid, mrx_ts} <= {2'b00, ts, TS};
      if (ts)
         @(posedge pclk);
      {mrx_ts_valid, mrx_stat_valid, mrx_stat} <= {2'b01, STAT};
      @(posedge pclk);
      mrx_stat_valid <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask
   task automatic expect_frame(input logic ts, input logic [31:0] st);
      int n;
      int k;
      n = (fr.size() + 3) / 4;
      k = n + ts + 1;
      for (int i = 0; i < 3000 && m.got.size() < rdi + k; i++)
         @(posedge pclk);
      for (int j = 0; j < n; j++)
         chk(m.got[rdi + j], {2'h0, j == n - 1, be_of(4 * j), w(4 * j)});
      if (ts)
         chk(m.got[rdi + n], {3'h2, 4'h0, TS});
      chk(m.got[rdi + k - 1], {3'h4, 4'hf, st});
      rdi += k;
   endtask
   initial begin
      #1800000;
      num_errors++;
      $display("wrong value at %0t: run timed out", $time);
      complete_run;
   end
   initial begin
      int k;
      {presetn, psel, penable, pwrite, paddr, pwdata, mrx_valid, mrx_data, mrx_be} = '0;
      {mrx_eof, mrx_ts_valid, mrx_ts, mrx_stat_valid, mrx_stat, dma_no_desc, stall, slow} = '0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rchk(8'h00, 32'h0, 1'b0);
      rchk(8'h08, 32'h0, 1'b0);
      wr(8'h0c, 32'hffffffff);
      rchk(8'h0c, 32'h0, 1'b1);
      wr(8'h04, 32'hffffffff);
      rchk(8'h04, 32'h0, 1'b0);
      for (int c = 0; c < 6; c++) begin
         slow <= (c == 1);
         build(c >= 3, c % 3 == 1, c % 3 == 2, 23);
         send(c[0]);
         expect_frame(c[0], STAT | (c % 3 != 0));
      end
      // Stalled host overflows the FIFO
      stall <= 1'b1;
      fr = {};
      for (int i = 0; i < 96; i++)
         fr.push_back(i[7:0]);
      send(1'b1);
      stall <= 1'b0;
      for (int i = 0; i < 3000 && !(m.got.size() > rdi
         && m.got[m.got.size() - 1][38:37] == 2'h2); i++)
         @(posedge pclk);
      repeat (20) @(posedge pclk);
      k = m.got.size() - rdi;
      chk(k >= 4 && k <= 18, 1'b1);
      for (int j = 0; j < k - 2; j++)
         chk(m.got[rdi + j], {3'h0, 4'hf, w(4 * j)});
      chk(m.got[rdi + k - 2], {3'h1, 4'hf, 32'h0});
      chk(m.got[rdi + k - 1], {3'h4, 4'hf, 32'h2});
      rdi += k;
      rchk(8'h04, 32'h00020000, 1'b0);
      build(1'b0, 1'b0, 1'b0, 23);
      send(1'b1);
      expect_frame(1'b1, STAT);
      // Store-and-forward, short frames
      wr(8'h00, 32'h02000000);
      build(1'b0, 1'b1, 1'b0, 11);
      send(1'b0);
      repeat (30) @(posedge pclk);
      build(1'b0, 1'b0, 1'b0, 11);
      send(1'b0);
      expect_frame(1'b0, STAT);
      wr(8'h00, 32'h06000000);
      rchk(8'h00, 32'h06000000, 1'b0);
      build(1'b0, 1'b1, 1'b0, 11);
      send(1'b0);
      expect_frame(1'b0, STAT | 32'h1);
      dma_no_desc <= 1'b1;
      repeat (65541) @(posedge pclk);
      dma_no_desc <= 1'b0;
      rchk(8'h04, 32'h00030005, 1'b0);
      rchk(8'h04, 32'h00020005, 1'b0);
      rchk(8'h08, 32'h0, 1'b0);
      complete_run;
   end
endmodule // eth_rx_checksum_fifo_status_tb_top
`default_nettype wire
